// ### logic/mmd_decoder.v
// cpu address decoder for the single-port and dual-strobe variants
`timescale 1ns/1ps
`default_nettype none
`include "mmd_map.vh"
module mmd_decoder #(
  parameter DUAL_STROBE = 0
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // mode pin
  input wire boot_mode_select_pin_i,
  // cpu access
  input wire access_valid_i,
  input wire [`MMD_ADDR_W-1:0] access_addr_i,
  input wire [`MMD_VTP_W-1:0] vector_table_pointer_i,
  input wire [`MMD_VEC_W-1:0] vector_index_i,
  // target selects
  output reg rom_sel_o,
  output reg ram0_sel_o,
  output reg ram1_sel_o,
  output reg peri_sel_o,
  output reg primary_memory_strobe_o,
  output reg memory_strobe_zero_o,
  output reg memory_strobe_one_o,
  output reg io_space_strobe_o,
  output reg reserved_hit_o,
  output reg branch_slot_o,
  output reg [`MMD_ADDR_W-1:0] vector_addr_o,
  output reg boot_mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function in_rng;
    input [`MMD_ADDR_W-1:0] a;
    input [`MMD_ADDR_W-1:0] lo;
    input [`MMD_ADDR_W-1:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  function [`MMD_TGT_W-1:0] onehot;
    input integer idx;
    begin
      onehot = 8'h01 << idx;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode pin
  wire mode_w;
  mmd_pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(boot_mode_select_pin_i),
    .level_o(mode_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  reg [`MMD_TGT_W-1:0] tgt_nxt;
  reg branch_nxt;
  reg res_nxt;
  reg [`MMD_ADDR_W-1:0] vec_nxt;

  // single-port map; only the low region depends on the mode
  function [`MMD_TGT_W-1:0] sp_target;
    input [`MMD_ADDR_W-1:0] a;
    input m;
    begin
      if (a <= `MMD_LOW_HI) begin
        if (m && in_rng(a, `MMD_BOOT_LO, `MMD_BOOT_HI)) begin
          sp_target = onehot(`MMD_T_ROM);
        end else begin
          sp_target = onehot(`MMD_T_PRIM);
        end
      end else if (in_rng(a, `MMD_PERI_LO, `MMD_PERI_HI)) begin
        sp_target = onehot(`MMD_T_PERI);
      end else if (in_rng(a, `MMD_RSV0_LO, `MMD_RSV0_HI)) begin
        sp_target = 8'h00;
      end else if (in_rng(a, `MMD_SP_RAM0_LO, `MMD_SP_RAM0_HI)) begin
        sp_target = onehot(`MMD_T_RAM0);
      end else if (in_rng(a, `MMD_SP_RAM1_LO, `MMD_SP_RAM1_HI)) begin
        sp_target = onehot(`MMD_T_RAM1);
      end else if (in_rng(a, `MMD_SP_EXT_LO, `MMD_TOP)) begin
        sp_target = onehot(`MMD_T_PRIM);
      end else begin
        sp_target = 8'h00;
      end
    end
  endfunction

  // dual-strobe map; three reserved holes select nothing
  function [`MMD_TGT_W-1:0] ds_target;
    input [`MMD_ADDR_W-1:0] a;
    input m;
    begin
      if (a <= `MMD_LOW_HI) begin
        if (m && in_rng(a, `MMD_BOOT_LO, `MMD_BOOT_HI)) begin
          ds_target = onehot(`MMD_T_ROM);
        end else begin
          ds_target = onehot(`MMD_T_S0);
        end
      end else if (in_rng(a, `MMD_PERI_LO, `MMD_PERI_HI)) begin
        ds_target = onehot(`MMD_T_PERI);
      end else if (in_rng(a, `MMD_RSV0_LO, `MMD_RSV0_HI)) begin
        ds_target = 8'h00;
      end else if (in_rng(a, `MMD_DS_RSV1_LO, `MMD_DS_RSV1_HI)) begin
        ds_target = 8'h00;
      end else if (in_rng(a, `MMD_DS_IO_LO, `MMD_DS_IO_HI)) begin
        ds_target = onehot(`MMD_T_IO);
      end else if (in_rng(a, `MMD_DS_RSV2_LO, `MMD_DS_RSV2_HI)) begin
        ds_target = 8'h00;
      end else if (in_rng(a, `MMD_DS_RAM0_LO, `MMD_DS_RAM0_HI)) begin
        ds_target = onehot(`MMD_T_RAM0);
      end else if (in_rng(a, `MMD_DS_RAM1_LO, `MMD_DS_RAM1_HI)) begin
        ds_target = onehot(`MMD_T_RAM1);
      end else if (in_rng(a, `MMD_DS_S0_LO, `MMD_DS_S0_HI)) begin
        ds_target = onehot(`MMD_T_S0);
      end else begin
        ds_target = onehot(`MMD_T_S1);
      end
    end
  endfunction

  // vector fetch address for one vector number
  function [`MMD_ADDR_W-1:0] vec_of;
    input [`MMD_VTP_W-1:0] ptr;
    input [`MMD_VEC_W-1:0] idx;
    input m;
    begin
      if (DUAL_STROBE != 0) begin
        vec_of = {ptr, idx};
      end else if (m && (idx != 8'h00)) begin
        vec_of = `MMD_SP_BRANCH_LO - 24'h000001 + {16'h0000, idx};
      end else begin
        vec_of = {16'h0000, idx};
      end
    end
  endfunction

  always @* begin
    tgt_nxt = 8'h00;
    branch_nxt = 1'b0;
    if (access_valid_i) begin
      if (DUAL_STROBE != 0) begin
        tgt_nxt = ds_target(access_addr_i, mode_w);
      end else begin
        tgt_nxt = sp_target(access_addr_i, mode_w);
        branch_nxt = mode_w && in_rng(access_addr_i, `MMD_SP_BRANCH_LO,
                                      `MMD_SP_BRANCH_HI);
      end
    end
    res_nxt = access_valid_i && (tgt_nxt == 8'h00);
  end

  // vector address
  always @* begin
    vec_nxt = vec_of(vector_table_pointer_i, vector_index_i, mode_w);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered selects
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rom_sel_o <= 1'b0;
      ram0_sel_o <= 1'b0;
      ram1_sel_o <= 1'b0;
      peri_sel_o <= 1'b0;
      primary_memory_strobe_o <= 1'b0;
      memory_strobe_zero_o <= 1'b0;
      memory_strobe_one_o <= 1'b0;
      io_space_strobe_o <= 1'b0;
      reserved_hit_o <= 1'b0;
      branch_slot_o <= 1'b0;
    end else begin
      rom_sel_o <= tgt_nxt[`MMD_T_ROM];
      ram0_sel_o <= tgt_nxt[`MMD_T_RAM0];
      ram1_sel_o <= tgt_nxt[`MMD_T_RAM1];
      peri_sel_o <= tgt_nxt[`MMD_T_PERI];
      primary_memory_strobe_o <= tgt_nxt[`MMD_T_PRIM];
      memory_strobe_zero_o <= tgt_nxt[`MMD_T_S0];
      memory_strobe_one_o <= tgt_nxt[`MMD_T_S1];
      io_space_strobe_o <= tgt_nxt[`MMD_T_IO];
      reserved_hit_o <= res_nxt;
      branch_slot_o <= branch_nxt;
    end
  end

  // registered vector address and settled mode
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vector_addr_o <= 24'h000000;
      boot_mode_o <= 1'b0;
    end else begin
      vector_addr_o <= vec_nxt;
      boot_mode_o <= mode_w;
    end
  end
endmodule // mmd_decoder
`default_nettype wire

// ### logic/mmd_map.vh
// address map constants for the memory map decoder
`ifndef MMD_MAP_VH
`define MMD_MAP_VH
`define MMD_ADDR_W 24
`define MMD_BOOT_LO 24'h000000
`define MMD_BOOT_HI 24'h000FFF
`define MMD_VEC_HI 24'h00003F
`define MMD_LOW_HI 24'h7FFFFF
`define MMD_RSV0_LO 24'h800000
`define MMD_RSV0_HI 24'h807FFF
`define MMD_PERI_LO 24'h808000
`define MMD_PERI_HI 24'h8097FF
`define MMD_SP_RAM0_LO 24'h809800
`define MMD_SP_RAM0_HI 24'h809BFF
`define MMD_SP_RAM1_LO 24'h809C00
`define MMD_SP_RAM1_HI 24'h809FFF
`define MMD_SP_BRANCH_LO 24'h809FC1
`define MMD_SP_BRANCH_HI 24'h809FFF
`define MMD_SP_EXT_LO 24'h80A000
`define MMD_DS_RSV1_LO 24'h809800
`define MMD_DS_RSV1_HI 24'h80FFFF
`define MMD_DS_IO_LO 24'h810000
`define MMD_DS_IO_HI 24'h82FFFF
`define MMD_DS_RSV2_LO 24'h830000
`define MMD_DS_RSV2_HI 24'h87FDFF
`define MMD_DS_RAM0_LO 24'h87FE00
`define MMD_DS_RAM0_HI 24'h87FEFF
`define MMD_DS_RAM1_LO 24'h87FF00
`define MMD_DS_RAM1_HI 24'h87FFFF
`define MMD_DS_S0_LO 24'h880000
`define MMD_DS_S0_HI 24'h8FFFFF
`define MMD_DS_S1_LO 24'h900000
`define MMD_TOP 24'hFFFFFF
`define MMD_VTP_W 16
`define MMD_VEC_W 8
`define MMD_TGT_W 8
`define MMD_T_ROM 0
`define MMD_T_RAM0 1
`define MMD_T_RAM1 2
`define MMD_T_PERI 3
`define MMD_T_PRIM 4
`define MMD_T_S0 5
`define MMD_T_S1 6
`define MMD_T_IO 7
`endif

// ### logic/mmd_pin_sync.v
// three-stage synchroniser for the boot mode select pin
`timescale 1ns/1ps
`default_nettype none
module mmd_pin_sync (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // pin in, settled level out
  input wire pin_i,
  output reg level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule // mmd_pin_sync
`default_nettype wire

// ### verif/memory_map_decoder_tb.sv
// self-checking testbench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin comparisons++; if ((e) !== (s)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module memory_map_decoder_tb;
  logic clk_i = 0, rst_i = 1, boot_mode_select_pin_i = 0, access_valid_i = 0;
  logic [23:0] access_addr_i = 24'h0, pa = 24'h0;
  logic [15:0] vector_table_pointer_i = 16'h0;
  logic [7:0] vector_index_i = 8'h0;
  logic pv = 0;
  logic [15:0] pp = 16'h0;
  logic [7:0] pi = 8'h0;
  wire logic [9:0] s [2];
  wire logic bm [2];
  wire logic [23:0] va [2];
  wire logic [15:0] hits;
  int fails = 0, comparisons = 0, exp_hits = 0;
  logic [23:0] tbl [30] = '{24'h0, 24'h3F, 24'h40, 24'hFFF, 24'h1000,
    24'h7FFFFF, 24'h800000, 24'h807FFF, 24'h808000, 24'h8097FF, 24'h809800,
    24'h809BFF, 24'h809C00, 24'h809FC0, 24'h809FC1, 24'h809FFF, 24'h80A000,
    24'h80FFFF, 24'h810000, 24'h82FFFF, 24'h830000, 24'h87FDFF, 24'h87FE00,
    24'h87FEFF, 24'h87FF00, 24'h87FFFF, 24'h880000, 24'h8FFFFF, 24'h900000,
    24'hFFFFFF};
  always #5 clk_i = ~clk_i;
  for (genvar g = 0; g < 2; g++) begin : u
    mmd_decoder #(.DUAL_STROBE(g)) dut (.clk_i, .rst_i,
      .boot_mode_select_pin_i, .access_valid_i, .access_addr_i,
      .vector_table_pointer_i, .vector_index_i, .rom_sel_o(s[g][0]),
      .ram0_sel_o(s[g][1]), .ram1_sel_o(s[g][2]), .peri_sel_o(s[g][3]),
      .primary_memory_strobe_o(s[g][4]), .memory_strobe_zero_o(s[g][5]),
      .memory_strobe_one_o(s[g][6]), .io_space_strobe_o(s[g][7]),
      .reserved_hit_o(s[g][8]), .branch_slot_o(s[g][9]),
      .vector_addr_o(va[g]), .boot_mode_o(bm[g]));
  end
  mmd_ext_mem ext (.clk_i, .strobe_i(s[0][4]), .hits_o(hits));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] ex(input bit d, m, input [23:0] a);
    ex = 10'h0;
    ex[9] = !d && m && a >= 24'h809FC1 && a <= 24'h809FFF;
    if (a < 24'h800000) ex[(m && a < 24'h1000) ? 0 : (d ? 5 : 4)] = 1;
    else if (a < 24'h808000) ex[8] = 1;
    else if (a < 24'h809800) ex[3] = 1;
    else if (!d) ex[a < 24'h809C00 ? 1 : a < 24'h80A000 ? 2 : 4] = 1;
    else if (a < 24'h810000 || (a >= 24'h830000 && a < 24'h87FE00)) ex[8] = 1;
    else if (a < 24'h830000) ex[7] = 1;
    else ex[a < 24'h87FF00 ? 1 : a < 24'h880000 ? 2 : a < 24'h900000 ? 5 : 6] = 1;
  endfunction
  function automatic logic [23:0] vx(input bit d, m, input [15:0] p,
      input [7:0] i);
    if (d) vx = {p, i};
    else if (m && i != 8'h00) vx = 24'h809FC0 + {16'h0, i};
    else vx = {16'h0, i};
  endfunction
  function automatic logic [23:0] rnd_addr();
    rnd_addr = 24'($urandom);
    if (rnd_addr[23:19] == 5'h10) rnd_addr[23] = 1'b0;
  endfunction
  task go(input bit m, v, input [23:0] a);
    logic [9:0] e;
    @(posedge clk_i);
    #1;
    e = pv ? ex(0, m, pa) : 10'h0;
    `CHK("single", e, s[0])
    `CHK("dual", pv ? ex(1, m, pa) : 10'h0, s[1])
    if (pv) begin
      `CHK("vec single", vx(0, m, pp, pi), va[0])
      `CHK("vec dual", vx(1, m, pp, pi), va[1])
    end
    if (e[4]) exp_hits++;
    pv = v;
    pa = a;
    access_valid_i = v;
    access_addr_i = a;
    vector_table_pointer_i = 16'($urandom);
    vector_index_i = 8'($urandom);
    pp = vector_table_pointer_i;
    pi = vector_index_i;
  endtask
  task wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(14));
    repeat (16) @(posedge clk_i);
    #1 rst_i = 0;
    for (int m = 0; m < 2; m++) begin
      boot_mode_select_pin_i = m[0];
      repeat (6) go(m[0], 0, 24'h0);
      `CHK("mode", m[0], bm[0])
      `CHK("mode dual", m[0], bm[1])
      foreach (tbl[i]) go(m[0], 1, tbl[i]);
      repeat (64) go(m[0], $urandom_range(3) != 0, rnd_addr());
      go(m[0], 0, 24'h0);
      $display("test mode %0d done", m);
    end
    @(posedge clk_i);
    #1;
    `CHK("hits", 16'(exp_hits), hits)
    wrap_up;
  end
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
endmodule // memory_map_decoder_tb
`default_nettype wire

// ### verif/mmd_checker.sv
// port assertions for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module mmd_checker #(
  parameter DUAL_STROBE = 0
) (
  // clock, reset and inputs
  input wire logic clk_i, rst_i, boot_mode_select_pin_i, access_valid_i,
  input wire logic [23:0] access_addr_i,
  input wire logic [15:0] vector_table_pointer_i,
  input wire logic [7:0] vector_index_i,
  // outputs
  input wire logic rom_sel_o, ram0_sel_o, ram1_sel_o, peri_sel_o,
  input wire logic primary_memory_strobe_o, memory_strobe_zero_o,
  input wire logic memory_strobe_one_o, io_space_strobe_o,
  input wire logic reserved_hit_o, branch_slot_o, boot_mode_o,
  input wire logic [23:0] vector_addr_o
);
  localparam D = DUAL_STROBE;
  wire logic v = access_valid_i;
  wire logic [23:0] a = access_addr_i;
  wire logic [8:0] sel = {reserved_hit_o, io_space_strobe_o,
    memory_strobe_one_o, memory_strobe_zero_o, primary_memory_strobe_o,
    peri_sel_o, ram1_sel_o, ram0_sel_o, rom_sel_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_one_hot: assert property ($onehot0(sel))
    else $error("more than one select");
  a_idle_quiet: assert property (!$past(v) |-> sel == 9'h0)
    else $error("select without access");
  a_peri_sel: assert property ($past(v && a >= 24'h808000 && a <= 24'h8097FF)
    |-> peri_sel_o) else $error("peripheral window missed");
  a_low_reserved: assert property ($past(v && a[23:15] == 9'h100)
    |-> reserved_hit_o) else $error("reserved not flagged");
  a_boot_rom: assert property ($past(v && a < 24'h001000)
    |-> rom_sel_o == boot_mode_o) else $error("boot rom select wrong");
  a_top_ext: assert property ($past(v && a >= (D ? 24'h900000 : 24'h80A000))
    |-> (D ? memory_strobe_one_o : primary_memory_strobe_o))
    else $error("top region strobe missing");
  a_ram_zero: assert property ($past(v && (D ? a[23:8] == 16'h87FE
    : a[23:10] == 14'h2026)) |-> ram0_sel_o) else $error("ram0 missed");
  a_branch_slot: assert property (!D && boot_mode_o &&
    $past(v && a >= 24'h809FC1 && a <= 24'h809FFF)
    |-> branch_slot_o && ram1_sel_o) else $error("branch slot missed");
  a_io_strobe: assert property ($past(v && a >= 24'h810000 && a < 24'h830000)
    |-> io_space_strobe_o == D) else $error("io strobe wrong");
  a_vec_base: assert property (D |-> vector_addr_o ==
    {$past(vector_table_pointer_i), $past(vector_index_i)})
    else $error("vector address wrong");
endmodule // mmd_checker
bind mmd_decoder mmd_checker #(.DUAL_STROBE(DUAL_STROBE)) chk (.*);
`default_nettype wire

// ### verif/mmd_ext_mem.sv
// external memory model counting strobed accesses
`timescale 1ns/1ps
`default_nettype none
module mmd_ext_mem (
  // clock and strobe
  input wire logic clk_i,
  input wire logic strobe_i,
  // accesses seen
  output var logic [15:0] hits_o = 16'h0
);
  always @(posedge clk_i) if (strobe_i === 1'b1) hits_o <= hits_o + 16'h1;
endmodule // mmd_ext_mem
`default_nettype wire
